/* File: core/fsb_pkg.sv */
// constants and types shared by the slave bus interface
`default_nettype none
package fsb_pkg;
	// ------------------------------------------------------------
	// status codes on the bus status lines
	// ------------------------------------------------------------
	localparam logic [3:0] STS_ID = 4'hF;
	localparam logic [3:0] STS_OPND = 4'hD;
	localparam logic [3:0] STS_STATUS = 4'hE;
	// ------------------------------------------------------------
	// protocol select codes {hi, lo}
	// ------------------------------------------------------------
	localparam logic [1:0] PS_16 = 2'h0;
	localparam logic [1:0] PS_32_T2 = 2'h3;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int IDLE_CLOCKS = 256;
	localparam int IDLE_CNT_W = 9;
	// ------------------------------------------------------------
	// data lanes
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int ID32_LSB = 24;
	localparam int OPLO32_LSB = 16;
	localparam int OPHI32_LSB = 8;
	localparam logic [31:0] LANE16_MASK = 32'h0000_FFFF;
	// ------------------------------------------------------------
	// status word fields and reset values
	// ------------------------------------------------------------
	localparam int SW_Q_BIT = 0;
	localparam int SW_Z_BIT = 1;
	localparam int SW_N_BIT = 2;
	localparam int SW_TS_BIT = 3;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] FSR_RESET = 32'h0000_0000;
	// ------------------------------------------------------------
	// protocol states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FSB_IDLE = 3'b000,
		FSB_OPWORD = 3'b001,
		FSB_OPND = 3'b010,
		FSB_EXEC = 3'b011,
		FSB_DONE = 3'b100,
		FSB_STAT = 3'b101,
		FSB_RESULT = 3'b110
	} fsb_state_e;
endpackage : fsb_pkg
`default_nettype wire

/* File: core/fsb_idle_timer.sv */
// strobe inactivity timer that flags power-down
`default_nettype none
module fsb_idle_timer
#(
	parameter int LIMIT = fsb_pkg::IDLE_CLOCKS,
	parameter int CNT_W = fsb_pkg::IDLE_CNT_W
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic restart,
	output logic expired
);
	import fsb_pkg::*;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

	if (LIMIT < 2 || LIMIT >= (1 << CNT_W))
	begin : g_bad_limit
		$error("fsb_idle_timer: LIMIT does not fit CNT_W");
	end

	logic [CNT_W-1:0] cnt;
	wire at_last = (cnt == LAST);
	wire [CNT_W-1:0] next_cnt = restart ? '0 : (at_last ? cnt : cnt + 1'b1);
	wire next_expired = !restart && (expired || at_last);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			expired <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			expired <= next_expired;
		end
	end

	AST_IDLE_EXPIRE:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(at_last && !restart) |=> expired)
	else $error("idle limit reached without power-down");

	AST_IDLE_RESTART:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		restart |=> (cnt == '0) && !expired)
	else $error("strobe did not restart the idle count");
endmodule : fsb_idle_timer
`default_nettype wire

/* File: core/fsb_core.sv */
// slave bus interface of the floating-point coprocessor
// Contract
// - power down after 256 clocks without strobe
// - strobe wakes device with no extra latency
// - reset abandons instruction, clears status register
// - each cycle moves byte, word or dword
// - host strobes; device tracks status lines
// - status sampled on strobe falling edge
// - high-performance host: sample in second state
// - read cycle: drive data while strobe low
// - write cycle: capture data on strobe rise
// - 16-bit: low lane bytes, low word first
// - 32-bit: long operand upper dword first
// - instruction opens with id and operation word
// - select pins choose 16 or 32-bit protocol
// - execute only after last operand arrives
// - 16-bit completion pulses strobe low
// - status word read with code 1110
// - result read only to memory, no trap
// - 16-bit operation word byte swapped
// - 32-bit id top byte, swapped op word
// - new id cancels protocol, selects one slave
// - exception sets trap pending bit
`default_nettype none
module fsb_core
#(
	parameter int IDLE_LIMIT = fsb_pkg::IDLE_CLOCKS,
	// own slave id byte; value is arbitrary
	parameter logic [7:0] OWN_ID = 8'h3E
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic slave_strobe_in,
	output logic slave_strobe_out,
	output logic slave_strobe_oe_n,
	input wire logic [3:0] bus_status_lines,
	input wire logic second_bus_state,
	input wire logic protocol_select_lo,
	input wire logic protocol_select_hi,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic data_oe_n,
	output logic core_clk_en,
	output logic op_valid,
	output logic [7:0] op_id,
	output logic [15:0] op_word,
	input wire logic [3:0] operand_cycles,
	input wire logic operand_long,
	output logic operand_valid,
	output logic [31:0] operand_data,
	output logic [1:0] operand_word_pos,
	output logic exec_start,
	input wire logic exec_done,
	input wire logic exec_trap,
	input wire logic exec_undef,
	input wire logic exec_cmp_z,
	input wire logic exec_cmp_n,
	input wire logic result_to_mem,
	input wire logic [3:0] result_cycles,
	input wire logic [31:0] result_word,
	output logic [3:0] result_index,
	output logic slave_done,
	input wire logic fsr_load,
	input wire logic [31:0] fsr_load_data,
	output logic [31:0] float_status_reg,
	output logic [31:0] status_word
);
	import fsb_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// strobe edges and status sampling
	// ------------------------------------------------------------
	logic strobe_prev;
	logic [3:0] cyc_status;
	fsb_state_e state;
	logic [3:0] opnd_left;
	logic [3:0] opnd_cnt;
	logic [3:0] res_left;
	logic pd_expired;

	wire [1:0] ps_code = {protocol_select_hi, protocol_select_lo};
	wire p32 = (ps_code != PS_16);
	wire t2_host = (ps_code == PS_32_T2);
	wire strobe_fall = strobe_prev && !slave_strobe_in;
	wire strobe_rise = !strobe_prev && slave_strobe_in;
	wire take_status = t2_host ? (second_bus_state && !slave_strobe_in)
		: strobe_fall;
	wire [3:0] cur_status = take_status ? bus_status_lines : cyc_status;
	wire [3:0] next_cyc_status = cur_status;

	// ------------------------------------------------------------
	// decode of the cycle that ends on this strobe rise
	// ------------------------------------------------------------
	wire end_id = strobe_rise && (cyc_status == STS_ID);
	wire end_op = strobe_rise && (cyc_status == STS_OPND);
	wire end_st = strobe_rise && (cyc_status == STS_STATUS);
	wire [7:0] id_byte = p32 ? data_in[ID32_LSB +: BYTE_W]
		: data_in[BYTE_W-1:0];
	wire [15:0] op32 = {data_in[OPHI32_LSB +: BYTE_W],
		data_in[OPLO32_LSB +: BYTE_W]};
	wire [15:0] op16 = {data_in[7:0], data_in[15:8]};
	wire id_hit = (id_byte == OWN_ID);
	wire [31:0] lane_data = p32 ? data_in : (data_in & LANE16_MASK);

	// ------------------------------------------------------------
	// read cycles drive the bus while the strobe is low
	// ------------------------------------------------------------
	wire rd_status = (state == FSB_STAT) && (cur_status == STS_STATUS);
	wire rd_result = (state == FSB_RESULT) && (cur_status == STS_OPND);
	wire read_drive = !slave_strobe_in && (rd_status || rd_result);
	wire [31:0] next_data_out = (state == FSB_RESULT) ? result_word : status_word;

	// ------------------------------------------------------------
	// word significance of the current operand cycle
	// ------------------------------------------------------------
	wire [1:0] pos32 = operand_long ? {1'b0, ~opnd_cnt[0]} : 2'b00;
	wire [1:0] pos16 = operand_long ? opnd_cnt[1:0]
		: {1'b0, opnd_cnt[0]};
	wire [1:0] next_pos = p32 ? pos32 : pos16;

	// ------------------------------------------------------------
	// protocol sequence
	// ------------------------------------------------------------
	fsb_state_e next_state;
	logic [3:0] next_opnd_left;
	logic next_exec_start;
	always_comb
	begin
		next_state = state;
		next_opnd_left = opnd_left;
		next_exec_start = 1'b0;
		if (end_id)
		begin
			// any id cancels the sequence in progress
			if (!id_hit)
				next_state = FSB_IDLE;
			else
				next_state = FSB_OPWORD;
		end
		else
		begin
			case (state)
				FSB_IDLE:
					next_state = FSB_IDLE;
				FSB_OPWORD:
				begin
					// 32-bit: op word came with the id; 16-bit: wait for it
					if (p32 || end_op)
					begin
						next_opnd_left = operand_cycles;
						next_state = FSB_OPND;
					end
				end
				FSB_OPND:
				begin
					if (opnd_left == 4'h0)
					begin
						next_exec_start = 1'b1;
						next_state = FSB_EXEC;
					end
					else if (end_op)
						next_opnd_left = opnd_left - 4'h1;
				end
				FSB_EXEC:
					if (exec_done)
						next_state = FSB_DONE;
				FSB_DONE:
					next_state = FSB_STAT;
				FSB_STAT:
					if (end_st)
					begin
						if (result_to_mem && !status_word[SW_Q_BIT]
							&& (result_cycles != 4'h0))
							next_state = FSB_RESULT;
						else
							next_state = FSB_IDLE;
					end
				FSB_RESULT:
					if (end_op && (res_left == 4'h1))
						next_state = FSB_IDLE;
				default:
					next_state = FSB_IDLE;
			endcase
		end
	end

	wire opnd_take = (state == FSB_OPND) && end_op && (opnd_left != 4'h0);
	wire op_take16 = (state == FSB_OPWORD) && !p32 && end_op;
	wire id_take = end_id && id_hit;
	wire exec_end = (state == FSB_EXEC) && exec_done;
	wire [3:0] next_res_left = (state == FSB_STAT) ? result_cycles
		: (((state == FSB_RESULT) && end_op) ? res_left - 4'h1 : res_left);
	wire [3:0] next_res_index = (state == FSB_STAT) ? 4'h0
		: (((state == FSB_RESULT) && end_op) ? result_index + 4'h1 : result_index);
	wire [3:0] next_opnd_cnt = (state == FSB_OPWORD) ? 4'h0
		: (opnd_take ? opnd_cnt + 4'h1 : opnd_cnt);

	// status word: trap set wins over the clear at a new id
	logic [31:0] next_status;
	always_comb
	begin
		next_status = status_word;
		if (id_take)
			next_status = STATUS_RESET;
		if (exec_end)
		begin
			next_status[SW_Q_BIT] = exec_trap || exec_undef;
			next_status[SW_TS_BIT] = exec_undef;
			next_status[SW_Z_BIT] = exec_cmp_z;
			next_status[SW_N_BIT] = exec_cmp_n;
		end
	end
	wire [31:0] next_fsr = fsr_load ? fsr_load_data : float_status_reg;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strobe_prev <= 1'b1;
			cyc_status <= 4'h0;
			state <= FSB_IDLE;
			opnd_left <= 4'h0;
			opnd_cnt <= 4'h0;
			res_left <= 4'h0;
			result_index <= 4'h0;
			exec_start <= 1'b0;
			status_word <= STATUS_RESET;
			float_status_reg <= FSR_RESET;
			data_out <= 32'h0000_0000;
		end
		else
		begin
			strobe_prev <= slave_strobe_in;
			cyc_status <= next_cyc_status;
			state <= next_state;
			opnd_left <= next_opnd_left;
			opnd_cnt <= next_opnd_cnt;
			res_left <= next_res_left;
			result_index <= next_res_index;
			exec_start <= next_exec_start;
			status_word <= next_status;
			float_status_reg <= next_fsr;
			data_out <= next_data_out;
		end
	end

	// captures on the trailing strobe edge
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_valid <= 1'b0;
			op_id <= 8'h00;
			op_word <= 16'h0000;
			operand_valid <= 1'b0;
			operand_data <= 32'h0000_0000;
			operand_word_pos <= 2'b00;
		end
		else
		begin
			op_valid <= (id_take && p32) || op_take16;
			if (id_take)
				op_id <= id_byte;
			if (id_take && p32)
				op_word <= op32;
			else if (op_take16)
				op_word <= op16;
			operand_valid <= opnd_take;
			if (opnd_take)
			begin
				operand_data <= lane_data;
				operand_word_pos <= next_pos;
			end
		end
	end

	// ------------------------------------------------------------
	// pin drive and power-down
	// ------------------------------------------------------------
	assign slave_done = (state == FSB_DONE);
	assign slave_strobe_out = 1'b0;
	assign slave_strobe_oe_n = !((state == FSB_DONE) && !p32);
	assign data_oe_n = !read_drive;
	assign core_clk_en = !pd_expired || strobe_fall;

	fsb_idle_timer #(
		.LIMIT(IDLE_LIMIT),
		.CNT_W(IDLE_CNT_W)
	) u_idle (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.restart(strobe_fall),
		.expired(pd_expired)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_WAKE_NO_DELAY:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		strobe_fall |-> core_clk_en ##1 core_clk_en)
	else $error("strobe did not wake the core at once");
	AST_READ_DRIVE:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == FSB_STAT && take_status && bus_status_lines == STS_STATUS)
		|-> !data_oe_n)
	else $error("status read not driven while strobe low");

	AST_WRITE_CAPTURE:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(opnd_take && p32) |=> operand_valid && operand_data == $past(data_in))
	else $error("operand not captured on strobe rise");

	AST_OPWORD_SWAP:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_take16 |=> op_valid
		&& op_word == {$past(data_in[7:0]), $past(data_in[15:8])})
	else $error("16-bit operation word not swapped");

	AST_DONE_PULSE:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(exec_end && !p32) |=> !slave_strobe_oe_n ##1 slave_strobe_oe_n)
	else $error("completion pulse not one cycle");

	AST_TRAP_PENDING:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(exec_end && exec_trap) |=> status_word[SW_Q_BIT] && state == FSB_DONE)
	else $error("trap did not set the pending bit");

	AST_EXEC_AFTER_LAST:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		exec_start |-> $past(state) == FSB_OPND && $past(opnd_left) == 4'h0)
	else $error("execution started before last operand");
	AST_FOREIGN_ID:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		(end_id && !id_hit) |=> state == FSB_IDLE)
	else $error("foreign id did not cancel the sequence");
	AST_FSR_CLEAR:
	assert property (@(posedge clk_sys) $rose(rst_n)
		|-> float_status_reg == FSR_RESET && state == FSB_IDLE)
	else $error("reset left status register set");
endmodule : fsb_core
`default_nettype wire

/* File: dv/fsb_host_model.sv */
// host side model: runs slave bus cycles and resolves the shared pins
`default_nettype none
module fsb_host_model
(
	input wire logic clk_sys,
	input wire logic strobe_oe_n,
	input wire logic strobe_drv,
	input wire logic [31:0] dev_data,
	input wire logic dev_oe_n,
	output logic strobe_pin,
	output var logic [3:0] sts = 4'h0,
	output var logic sbs = 1'b0,
	output logic [31:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic host_strobe_n = 1'b1;
	logic [31:0] host_data = 32'h0000_0000;
	// pulled up wire: either party may pull it low
	assign strobe_pin = host_strobe_n & (strobe_oe_n | strobe_drv);
	assign bus = dev_oe_n ? host_data : dev_data;
	// ------------------------------------------------------------
	// one bus cycle: strobe low three clocks, then high
	// ------------------------------------------------------------
	task automatic cycle(input logic [3:0] code, input logic [31:0] wdata,
		output logic [31:0] rdata);
		@(posedge clk_sys);
		host_strobe_n <= 1'b0;
		sts <= code;
		host_data <= wdata;
		@(posedge clk_sys);
		sbs <= 1'b1;
		@(posedge clk_sys);
		sbs <= 1'b0;
		@(posedge clk_sys);
		rdata = bus;
		host_strobe_n <= 1'b1;
		@(posedge clk_sys);
		// released lines show the inverse so stale values never match
		host_data <= ~wdata;
		sts <= ~code;
	endtask : cycle
endmodule : fsb_host_model
`default_nettype wire

/* File: dv/fsb_core_test.sv */
// self-checking bench for the coprocessor slave bus interface
`default_nettype none
module fsb_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fsb_pkg::*;
	localparam int LIM = 16;
	// own slave id; value is arbitrary
	localparam logic [7:0] MY_ID = 8'h5A;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic protocol_select_lo = 1'b0;
	logic protocol_select_hi = 1'b0;
	logic [3:0] operand_cycles = 4'h0;
	logic operand_long = 1'b0;
	logic exec_done = 1'b0;
	logic exec_trap = 1'b0;
	logic exec_undef = 1'b0;
	logic exec_cmp_z = 1'b0;
	logic exec_cmp_n = 1'b0;
	logic result_to_mem = 1'b0;
	logic [3:0] result_cycles = 4'h0;
	logic [31:0] result_word = 32'h0000_0000;
	logic fsr_load = 1'b0;
	logic [31:0] fsr_load_data = 32'h0000_0000;
	wire strobe_pin, slave_strobe_out, slave_strobe_oe_n, second_bus_state, data_oe_n;
	wire core_clk_en, op_valid, operand_valid, exec_start, slave_done;
	wire [3:0] bus_status_lines, result_index;
	wire [31:0] data_in, data_out, operand_data, float_status_reg, status_word;
	wire [7:0] op_id;
	wire [15:0] op_word;
	wire [1:0] operand_word_pos;
	logic [31:0] rd;
	logic [31:0] dq[$];
	logic [1:0] pq[$];
	int fails = 0, n_checks = 0, n_op = 0, at_exec = 0, ewait = 0, cyc = 0, n0;

	fsb_core #(.IDLE_LIMIT(LIM), .OWN_ID(MY_ID)) dut_u
	(
		.clk_sys, .arst_n, .slave_strobe_in(strobe_pin), .slave_strobe_out,
		.slave_strobe_oe_n, .bus_status_lines, .second_bus_state, .protocol_select_lo,
		.protocol_select_hi, .data_in, .data_out, .data_oe_n, .core_clk_en, .op_valid,
		.op_id, .op_word, .operand_cycles, .operand_long, .operand_valid, .operand_data,
		.operand_word_pos, .exec_start, .exec_done, .exec_trap, .exec_undef, .exec_cmp_z,
		.exec_cmp_n, .result_to_mem, .result_cycles, .result_word, .result_index,
		.slave_done, .fsr_load, .fsr_load_data, .float_status_reg, .status_word
	);
	fsb_host_model host_u
	(
		.clk_sys, .strobe_oe_n(slave_strobe_oe_n), .strobe_drv(slave_strobe_out),
		.dev_data(data_out), .dev_oe_n(data_oe_n), .strobe_pin,
		.sts(bus_status_lines), .sbs(second_bus_state), .bus(data_in)
	);

	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// datapath stand-in and pulse monitor
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		exec_done <= (ewait == 1);
		if (ewait > 0)
			ewait <= ewait - 1;
		if (exec_start === 1'b1)
		begin
			ewait <= 3;
			at_exec <= dq.size();
		end
		if (op_valid === 1'b1)
			n_op <= n_op + 1;
		if (operand_valid === 1'b1)
		begin
			dq.push_back(operand_data);
			pq.push_back(operand_word_pos);
		end
		if (cyc == 5000)
		begin
			fails++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_checks++;
		if (seen !== want)
		begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic do_reset;
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (64) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(float_status_reg, 32'h0000_0000);
		check(status_word, 32'h0000_0000);
		check({data_oe_n, slave_strobe_oe_n, core_clk_en}, 3'h7);
	endtask : do_reset

	task automatic send_id(input logic m32, input logic [7:0] id, input logic [15:0] op);
		dq.delete();
		pq.delete();
		if (m32)
			host_u.cycle(STS_ID, {id, op[7:0], op[15:8], 8'h00}, rd);
		else
		begin
			host_u.cycle(STS_ID, {24'h00_0000, id}, rd);
			host_u.cycle(STS_OPND, {16'h0000, op[7:0], op[15:8]}, rd);
		end
	endtask : send_id

	task automatic wait_done(input logic m32, input int nopnd);
		int k;
		k = 0;
		while (slave_done !== 1'b1 && k < 50)
		begin
			@(negedge clk_sys);
			k++;
		end
		check(k < 50, 1'b1);
		check(strobe_pin, m32);
		check(at_exec, nopnd);
		// let the completion pulse end before the host strobes again
		@(posedge clk_sys);
	endtask : wait_done

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_16;
		@(posedge clk_sys);
		{operand_cycles, operand_long} <= {4'h2, 1'b0};
		{exec_cmp_z, exec_cmp_n, exec_trap, exec_undef} <= 4'b1000;
		{result_to_mem, result_cycles, result_word} <= {1'b1, 4'h1, 32'hCAFE_F00D};
		send_id(1'b0, MY_ID, 16'hA55A);
		host_u.cycle(STS_OPND, 32'h0000_1111, rd);
		host_u.cycle(STS_OPND, 32'h0000_2222, rd);
		wait_done(1'b0, 2);
		check({op_id, op_word}, {8'h00, MY_ID, 16'hA55A});
		check({dq[0], pq[0]}, {32'h0000_1111, 2'h0});
		check({dq[1], pq[1]}, {32'h0000_2222, 2'h1});
		host_u.cycle(STS_STATUS, 32'h0000_0000, rd);
		check(rd, 32'h0000_0001 << SW_Z_BIT);
		host_u.cycle(STS_OPND, 32'h0000_0000, rd);
		check(rd[15:0], 16'hF00D);
		@(negedge clk_sys);
		check(result_index, 4'h1);
	endtask : t_16

	task automatic t_trap;
		n0 = n_op;
		send_id(1'b0, 8'h11, 16'h0000);
		repeat (3) @(posedge clk_sys);
		check(n_op, n0);
		{operand_cycles, exec_cmp_z, exec_trap, exec_undef} <= {4'h0, 3'b011};
		send_id(1'b0, MY_ID, 16'h1234);
		wait_done(1'b0, 0);
		host_u.cycle(STS_STATUS, 32'h0000_0000, rd);
		check({rd[SW_Q_BIT], rd[SW_TS_BIT]}, 2'h3);
		{exec_trap, exec_undef} <= 2'b00;
		send_id(1'b0, MY_ID, 16'h1234);
		wait_done(1'b0, 0);
		host_u.cycle(STS_STATUS, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
	endtask : t_trap

	task automatic t_32(input logic [1:0] ps);
		{protocol_select_hi, protocol_select_lo} <= ps;
		{operand_cycles, operand_long, exec_cmp_n, result_to_mem} <= {4'h2, 3'b110};
		send_id(1'b1, MY_ID, {14'h30EC, ps});
		host_u.cycle(STS_OPND, 32'h7654_3210, rd);
		host_u.cycle(STS_OPND, 32'hFEDC_BA98, rd);
		wait_done(1'b1, 2);
		check(op_word, {14'h30EC, ps});
		check({dq[0], pq[0]}, {32'h7654_3210, 2'h1});
		check({dq[1], pq[1]}, {32'hFEDC_BA98, 2'h0});
		host_u.cycle(STS_STATUS, 32'h0000_0000, rd);
		check(rd, 32'h0000_0001 << SW_N_BIT);
	endtask : t_32

	task automatic t_power;
		{protocol_select_hi, protocol_select_lo} <= 2'h0;
		{operand_cycles, operand_long} <= {4'h4, 1'b1};
		repeat (LIM - 8) @(posedge clk_sys);
		@(negedge clk_sys);
		check(core_clk_en, 1'b1);
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		check(core_clk_en, 1'b0);
		n0 = n_op;
		send_id(1'b0, MY_ID, 16'h0F0F);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check(n_op, n0 + 1);
		check({core_clk_en, op_word}, {1'b1, 16'h0F0F});
		for (int i = 0; i < 4; i++)
			host_u.cycle(STS_OPND, 32'h0000_0100 + i, rd);
		wait_done(1'b0, 4);
		check({pq[0], pq[1], pq[2], pq[3]}, 8'h1B);
		check(dq[3], 32'h0000_0103);
	endtask : t_power

	task automatic t_rst;
		@(posedge clk_sys);
		fsr_load <= 1'b1;
		fsr_load_data <= 32'hDEAD_BEEF;
		@(posedge clk_sys);
		fsr_load <= 1'b0;
		@(negedge clk_sys);
		check(float_status_reg, 32'hDEAD_BEEF);
		send_id(1'b0, MY_ID, 16'h4444);
		do_reset();
		n0 = n_op;
		dq.delete();
		host_u.cycle(STS_OPND, 32'h0000_1234, rd);
		repeat (3) @(posedge clk_sys);
		check(n_op + dq.size(), n0);
	endtask : t_rst

	initial
	begin
		do_reset();
		t_16();
		t_trap();
		t_32(2'h1);
		t_32(2'h2);
		t_32(2'h3);
		t_power();
		t_rst();
		wrap_up();
	end
endmodule : fsb_core_test
`default_nettype wire
